// ===== rtl/flash_security_pkg.sv
package flash_security_pkg;
  // Security word location and encoding
  localparam logic [23:0] SEC_WORD_ADDR = 24'h007ff7;
  localparam int SEC_BIT_HI = 1;
  localparam int SEC_BIT_LO = 0;
  // Chip-level TAP instruction register
  localparam int IR_WIDTH = 4;
  localparam logic [3:0] IR_IDCODE = 4'h2;
  localparam logic [3:0] IR_BYPASS = 4'hf;
  localparam logic [3:0] IR_UNLOCK = 4'h8;
  localparam logic [3:0] IR_RESET_VAL = 4'h2;
  // Clock divider data register width
  localparam int DIV_WIDTH = 7;
  localparam logic [6:0] DIV_RESET = 7'h00;
  // Identification value, arbitrary
  localparam logic [31:0] ID_VALUE = 32'h0a5a5001;
  // Erase timing: divided ticks per erase
  localparam int ERASE_TICKS = 16;
  // Read delay of nonvolatile word after reset exit
  localparam int NV_READ_CYCLES = 2;
  // TAP state encoding
  typedef enum logic [3:0] {
    tap_reset = 4'h0, tap_idle = 4'h1, tap_sel_dr = 4'h2, tap_cap_dr = 4'h3,
    tap_sh_dr = 4'h4, tap_ex1_dr = 4'h5, tap_pa_dr = 4'h6, tap_ex2_dr = 4'h7,
    tap_up_dr = 4'h8, tap_sel_ir = 4'h9, tap_cap_ir = 4'ha, tap_sh_ir = 4'hb,
    tap_ex1_ir = 4'hc, tap_pa_ir = 4'hd, tap_ex2_ir = 4'he, tap_up_ir = 4'hf
  } tap_state_t;
  // Security controller states
  typedef enum logic [2:0] {
    sec_boot = 3'h0, sec_read = 3'h1, sec_locked = 3'h2,
    sec_open = 3'h3, sec_erase = 3'h4, sec_done = 3'h5
  } sec_state_t;
endpackage : flash_security_pkg

// ===== rtl/pin_sync.sv
`timescale 1ns/1ps
module pin_sync #(
  parameter int WIDTH = 1
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic [WIDTH-1:0] pin_in,
  output logic [WIDTH-1:0] level_out
);
  logic [WIDTH-1:0] s1_reg;
  logic [WIDTH-1:0] s2_reg;
  logic [WIDTH-1:0] s3_reg;
  // Three stage chain, second and third compared
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      s1_reg <= '0;
      s2_reg <= '0;
      s3_reg <= '0;
    end
    else
    begin
      s1_reg <= pin_in;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
    end
  end
  // Accept change once stages agree
  always_ff @(posedge core_clk)
  begin
    if (rst)
      level_out <= '0;
    else
    begin
      for (int i = 0; i < WIDTH; i++)
      begin
        if (s2_reg[i] == s3_reg[i])
          level_out[i] <= s3_reg[i];
      end
    end
  end
endmodule : pin_sync

// ===== rtl/flash_security_lockout_recovery.sv
`timescale 1ns/1ps
// Operation
// - Secure when word bit1=1 and bit0=0
// - Secure state re-derived after every reset
// - Secured: emulation unit debug disabled
// - TAP bypass and ID always usable
// - Secured: debug flash reads blocked from reset
// - Recovery erases whole flash, clears protection
// - Erase finishes before security drops
// - Host shifts 7-bit divider timing erase
// - Erase starts on entering Run-Test/Idle
// - Power-on reset resets TAP and device
// - One 4-pin JTAG serves TAP and emulation
module flash_security_lockout_recovery #(
  parameter int DIV_W = flash_security_pkg::DIV_WIDTH,
  parameter int TICKS = flash_security_pkg::ERASE_TICKS
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic por,
  input wire logic tck,
  input wire logic tms,
  input wire logic tdi,
  output logic tdo,
  output logic tdo_oe_n,
  output logic [23:0] nv_addr,
  input wire logic [15:0] nv_data,
  input wire logic debug_flash_req,
  output logic debug_flash_grant,
  output logic emu_debug_enable,
  output logic mass_erase_start,
  input wire logic mass_erase_done,
  output logic secured,
  output logic erase_busy,
  output logic erase_complete,
  output logic [DIV_W-1:0] erase_clk_div
);
  logic [2:0] pins;
  logic tck_s;
  logic tms_s;
  logic tdi_s;
  logic tck_d_reg;
  logic tck_rise;
  logic tck_fall;
  logic any_rst;
  flash_security_pkg::tap_state_t tap_reg;
  flash_security_pkg::tap_state_t tap_next;
  flash_security_pkg::sec_state_t sec_reg;
  logic [flash_security_pkg::IR_WIDTH-1:0] ir_reg;
  logic [flash_security_pkg::IR_WIDTH-1:0] ir_sh_reg;
  logic [31:0] dr_sh_reg;
  logic [DIV_W-1:0] div_reg;
  logic [DIV_W-1:0] div_cnt_reg;
  logic [7:0] tick_reg;
  logic [2:0] nv_wait_reg;
  logic erase_done_seen_reg;

  assign any_rst = rst | por;
  // Synchronise the shared JTAG pins
  pin_sync #(.WIDTH(3)) u_sync (
    .core_clk(core_clk),
    .rst(any_rst),
    .pin_in({tck, tms, tdi}),
    .level_out(pins)
  );
  assign tck_s = pins[2];
  assign tms_s = pins[1];
  assign tdi_s = pins[0];
  assign tck_rise = tck_s & ~tck_d_reg;
  assign tck_fall = ~tck_s & tck_d_reg;

  // TCK edge detect
  always_ff @(posedge core_clk)
  begin
    if (any_rst)
      tck_d_reg <= 1'b0;
    else
      tck_d_reg <= tck_s;
  end

  // TAP next state
  always_comb
  begin
    tap_next = tap_reg;
    case (tap_reg)
      flash_security_pkg::tap_reset:
        tap_next = tms_s ? flash_security_pkg::tap_reset : flash_security_pkg::tap_idle;
      flash_security_pkg::tap_idle:
        tap_next = tms_s ? flash_security_pkg::tap_sel_dr : flash_security_pkg::tap_idle;
      flash_security_pkg::tap_sel_dr:
        tap_next = tms_s ? flash_security_pkg::tap_sel_ir : flash_security_pkg::tap_cap_dr;
      flash_security_pkg::tap_cap_dr, flash_security_pkg::tap_sh_dr:
        tap_next = tms_s ? flash_security_pkg::tap_ex1_dr : flash_security_pkg::tap_sh_dr;
      flash_security_pkg::tap_ex1_dr:
        tap_next = tms_s ? flash_security_pkg::tap_up_dr : flash_security_pkg::tap_pa_dr;
      flash_security_pkg::tap_pa_dr:
        tap_next = tms_s ? flash_security_pkg::tap_ex2_dr : flash_security_pkg::tap_pa_dr;
      flash_security_pkg::tap_ex2_dr:
        tap_next = tms_s ? flash_security_pkg::tap_up_dr : flash_security_pkg::tap_sh_dr;
      flash_security_pkg::tap_up_dr, flash_security_pkg::tap_up_ir:
        tap_next = tms_s ? flash_security_pkg::tap_sel_dr : flash_security_pkg::tap_idle;
      flash_security_pkg::tap_sel_ir:
        tap_next = tms_s ? flash_security_pkg::tap_reset : flash_security_pkg::tap_cap_ir;
      flash_security_pkg::tap_cap_ir, flash_security_pkg::tap_sh_ir:
        tap_next = tms_s ? flash_security_pkg::tap_ex1_ir : flash_security_pkg::tap_sh_ir;
      flash_security_pkg::tap_ex1_ir:
        tap_next = tms_s ? flash_security_pkg::tap_up_ir : flash_security_pkg::tap_pa_ir;
      flash_security_pkg::tap_pa_ir:
        tap_next = tms_s ? flash_security_pkg::tap_ex2_ir : flash_security_pkg::tap_pa_ir;
      flash_security_pkg::tap_ex2_ir:
        tap_next = tms_s ? flash_security_pkg::tap_up_ir : flash_security_pkg::tap_sh_ir;
      default:
        tap_next = flash_security_pkg::tap_reset;
    endcase
  end

  // TAP state register, active regardless of security
  always_ff @(posedge core_clk)
  begin
    if (any_rst)
      tap_reg <= flash_security_pkg::tap_reset;
    else if (tck_rise)
      tap_reg <= tap_next;
  end

  // Instruction register path
  always_ff @(posedge core_clk)
  begin
    if (any_rst || tap_reg == flash_security_pkg::tap_reset)
    begin
      ir_reg <= flash_security_pkg::IR_RESET_VAL;
      ir_sh_reg <= '0;
    end
    else if (tck_rise)
    begin
      if (tap_reg == flash_security_pkg::tap_cap_ir)
        ir_sh_reg <= {{(flash_security_pkg::IR_WIDTH-1){1'b0}}, 1'b1};
      else if (tap_reg == flash_security_pkg::tap_sh_ir)
        ir_sh_reg <= {tdi_s, ir_sh_reg[flash_security_pkg::IR_WIDTH-1:1]};
      else if (tap_reg == flash_security_pkg::tap_up_ir)
        ir_reg <= ir_sh_reg;
    end
  end

  // Data register path: ID, bypass, divider
  always_ff @(posedge core_clk)
  begin
    if (any_rst)
    begin
      dr_sh_reg <= '0;
      div_reg <= flash_security_pkg::DIV_RESET;
    end
    else if (tck_rise)
    begin
      if (tap_reg == flash_security_pkg::tap_cap_dr)
      begin
        if (ir_reg == flash_security_pkg::IR_IDCODE)
          dr_sh_reg <= flash_security_pkg::ID_VALUE;
        else if (ir_reg == flash_security_pkg::IR_UNLOCK)
          dr_sh_reg <= {{(32-DIV_W){1'b0}}, div_reg};
        else
          dr_sh_reg <= '0;
      end
      else if (tap_reg == flash_security_pkg::tap_sh_dr)
      begin
        if (ir_reg == flash_security_pkg::IR_UNLOCK)
          dr_sh_reg <= {{(32-DIV_W){1'b0}}, tdi_s, dr_sh_reg[DIV_W-1:1]};
        else if (ir_reg == flash_security_pkg::IR_IDCODE)
          dr_sh_reg <= {tdi_s, dr_sh_reg[31:1]};
        else
          dr_sh_reg <= {31'h00000000, tdi_s};
      end
      else if (tap_reg == flash_security_pkg::tap_up_dr &&
               ir_reg == flash_security_pkg::IR_UNLOCK)
        div_reg <= dr_sh_reg[DIV_W-1:0];
    end
  end

  // TDO driven on falling TCK during shifts
  always_ff @(posedge core_clk)
  begin
    if (any_rst)
    begin
      tdo <= 1'b0;
      tdo_oe_n <= 1'b1;
    end
    else if (tck_fall)
    begin
      tdo <= (tap_reg == flash_security_pkg::tap_sh_ir) ? ir_sh_reg[0] : dr_sh_reg[0];
      tdo_oe_n <= !(tap_reg == flash_security_pkg::tap_sh_ir ||
                    tap_reg == flash_security_pkg::tap_sh_dr);
    end
  end

  // Security controller: read word, gate debug, run erase
  always_ff @(posedge core_clk)
  begin
    if (any_rst)
    begin
      sec_reg <= flash_security_pkg::sec_boot;
      secured <= 1'b1;
      nv_wait_reg <= '0;
      erase_busy <= 1'b0;
      erase_complete <= 1'b0;
      mass_erase_start <= 1'b0;
      div_cnt_reg <= '0;
      tick_reg <= '0;
      erase_done_seen_reg <= 1'b0;
    end
    else
    begin
      mass_erase_start <= 1'b0;
      case (sec_reg)
        flash_security_pkg::sec_boot:
        begin
          nv_wait_reg <= '0;
          sec_reg <= flash_security_pkg::sec_read;
        end
        flash_security_pkg::sec_read:
        begin
          nv_wait_reg <= nv_wait_reg + 3'h1;
          if (nv_wait_reg == 3'(flash_security_pkg::NV_READ_CYCLES))
          begin
            if (nv_data[flash_security_pkg::SEC_BIT_HI] &&
                !nv_data[flash_security_pkg::SEC_BIT_LO])
            begin
              secured <= 1'b1;
              sec_reg <= flash_security_pkg::sec_locked;
            end
            else
            begin
              secured <= 1'b0;
              sec_reg <= flash_security_pkg::sec_open;
            end
          end
        end
        flash_security_pkg::sec_locked, flash_security_pkg::sec_open:
        begin
          if (tck_rise && ir_reg == flash_security_pkg::IR_UNLOCK &&
              tap_reg == flash_security_pkg::tap_up_dr &&
              tap_next == flash_security_pkg::tap_idle)
          begin
            sec_reg <= flash_security_pkg::sec_erase;
            mass_erase_start <= 1'b1;
            erase_busy <= 1'b1;
            div_cnt_reg <= '0;
            tick_reg <= '0;
            erase_done_seen_reg <= 1'b0;
          end
        end
        flash_security_pkg::sec_erase:
        begin
          if (mass_erase_done)
            erase_done_seen_reg <= 1'b1;
          if (div_cnt_reg >= div_reg)
          begin
            div_cnt_reg <= '0;
            if (tick_reg < 8'(TICKS))
              tick_reg <= tick_reg + 8'h01;
          end
          else
            div_cnt_reg <= div_cnt_reg + 1'b1;
          if ((erase_done_seen_reg || mass_erase_done) && tick_reg >= 8'(TICKS))
          begin
            erase_busy <= 1'b0;
            erase_complete <= 1'b1;
            sec_reg <= flash_security_pkg::sec_done;
          end
        end
        flash_security_pkg::sec_done: sec_reg <= flash_security_pkg::sec_done;
        default: sec_reg <= flash_security_pkg::sec_boot;
      endcase
    end
  end

  // Debug gates, closed until the word is evaluated
  always_ff @(posedge core_clk)
  begin
    if (any_rst)
    begin
      emu_debug_enable <= 1'b0;
      debug_flash_grant <= 1'b0;
      nv_addr <= flash_security_pkg::SEC_WORD_ADDR;
      erase_clk_div <= flash_security_pkg::DIV_RESET;
    end
    else
    begin
      emu_debug_enable <= (sec_reg == flash_security_pkg::sec_open);
      debug_flash_grant <= debug_flash_req &&
                           sec_reg == flash_security_pkg::sec_open;
      nv_addr <= flash_security_pkg::SEC_WORD_ADDR;
      erase_clk_div <= div_reg;
    end
  end
endmodule : flash_security_lockout_recovery

// ===== testbench/flash_security_lockout_recovery_checker.sv
`timescale 1ns/1ps
module flash_security_lockout_recovery_checker #(
  parameter int DIV_W = 7,
  parameter int TICKS = 16
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic por,
  input wire logic tck,
  input wire logic tms,
  input wire logic tdi,
  input wire logic tdo,
  input wire logic tdo_oe_n,
  input wire logic [23:0] nv_addr,
  input wire logic [15:0] nv_data,
  input wire logic debug_flash_req,
  input wire logic debug_flash_grant,
  input wire logic emu_debug_enable,
  input wire logic mass_erase_start,
  input wire logic mass_erase_done,
  input wire logic secured,
  input wire logic erase_busy,
  input wire logic erase_complete,
  input wire logic [DIV_W-1:0] erase_clk_div
);
  int busy_cnt;
  // Cycles spent in the running erase
  always_ff @(posedge core_clk)
  begin
    if (rst || por || !erase_busy)
      busy_cnt <= 0;
    else
      busy_cnt <= busy_cnt + 1;
  end
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (rst || por);
  sequence s_exit;
    $fell(rst || por);
  endsequence
  sequence s_begin;
    mass_erase_start ##1 (erase_busy && !mass_erase_start);
  endsequence
  property p_addr; nv_addr == flash_security_pkg::SEC_WORD_ADDR; endproperty
  a_addr: assert property (p_addr) else $error("security word address wrong");
  property p_sec_hold; s_exit |-> secured [*3]; endproperty
  a_sec_hold: assert property (p_sec_hold) else $error("not secured at reset exit");
  property p_grant_block; s_exit |-> !debug_flash_grant [*4]; endproperty
  a_grant_block: assert property (p_grant_block) else $error("grant at reset exit");
  property p_decode; s_exit |-> ##8 secured == (nv_data[1] && !nv_data[0]); endproperty
  a_decode: assert property (p_decode) else $error("security word decoded wrong");
  property p_sec_grant; secured |=> !debug_flash_grant; endproperty
  a_sec_grant: assert property (p_sec_grant) else $error("flash grant while secured");
  property p_emu; secured |=> !emu_debug_enable; endproperty
  a_emu: assert property (p_emu) else $error("emulation enabled while secured");
  property p_open;
    (!secured && debug_flash_req && !erase_busy && !erase_complete) [*2] |-> debug_flash_grant;
  endproperty
  a_open: assert property (p_open) else $error("grant missing while open");
  property p_start; mass_erase_start |-> s_begin; endproperty
  a_start: assert property (p_start) else $error("erase start not a pulse");
  property p_rise; $rose(erase_busy) |-> mass_erase_start || $past(mass_erase_start); endproperty
  a_rise: assert property (p_rise) else $error("erase without start");
  property p_len;
    $fell(erase_busy) |-> busy_cnt >= TICKS * (int'(erase_clk_div) + 1);
  endproperty
  a_len: assert property (p_len) else $error("erase shorter than divider allows");
  property p_keep; erase_busy || erase_complete |=> $stable(secured); endproperty
  a_keep: assert property (p_keep) else $error("security dropped before reset");
endmodule : flash_security_lockout_recovery_checker

bind flash_security_lockout_recovery flash_security_lockout_recovery_checker #(
  .DIV_W(DIV_W), .TICKS(TICKS)) i_chk (.core_clk, .rst, .por, .tck, .tms, .tdi, .tdo,
  .tdo_oe_n, .nv_addr, .nv_data, .debug_flash_req, .debug_flash_grant, .emu_debug_enable,
  .mass_erase_start, .mass_erase_done, .secured, .erase_busy, .erase_complete, .erase_clk_div);

// ===== testbench/jtag_flash_partner.sv
`timescale 1ns/1ps
module jtag_flash_partner #(
  parameter int HALF = 8,
  parameter int LAT = 20
) (
  input wire logic core_clk,
  output logic tck,
  output logic tms,
  output logic tdi,
  input wire logic tdo,
  input wire logic mass_erase_start,
  output logic mass_erase_done,
  output logic [15:0] nv_data
);
  int lat = -1;
  // Idle pins, tms high as by pull-up
  initial
  begin
    tck = 1'b0;
    tms = 1'b1;
    tdi = 1'b0;
    mass_erase_done = 1'b0;
    nv_data = 16'h0000;
  end
  // Erase engine: done pulse after a latency, word left erased
  always @(negedge core_clk)
  begin
    mass_erase_done <= (lat == 0);
    if (lat == 0)
      nv_data <= 16'hffff;
    lat <= mass_erase_start ? LAT : (lat < 0 ? -1 : lat - 1);
  end
  task automatic load(input logic [15:0] wd);
    @(negedge core_clk);
    nv_data = wd;
  endtask : load
  // One tck period, tdo taken just before the rising edge
  task automatic step(input logic m, input logic d, output logic b);
    @(negedge core_clk);
    tms = m;
    tdi = d;
    repeat (HALF) @(negedge core_clk);
    b = tdo;
    tck = 1'b1;
    repeat (HALF) @(negedge core_clk);
    tck = 1'b0;
  endtask : step
  task automatic tap_reset();
    logic b;
    repeat (5) step(1'b1, 1'b0, b);
    step(1'b0, 1'b0, b);
  endtask : tap_reset
  // IR or DR scan from idle, LSB first, ends parked in idle
  task automatic scan(input logic ir, input int n, input logic [31:0] v, output logic [31:0] q);
    logic b;
    q = 32'h0;
    step(1'b1, 1'b0, b);
    if (ir)
      step(1'b1, 1'b0, b);
    step(1'b0, 1'b0, b);
    step(1'b0, 1'b0, b);
    for (int i = 0; i < n; i++)
      step(i == n - 1, v[i], q[i]);
    step(1'b1, 1'b0, b);
    step(1'b0, 1'b0, b);
    tms = 1'b0;
  endtask : scan
endmodule : jtag_flash_partner

// ===== testbench/test_flash_security_lockout_recovery.sv
`timescale 1ns/1ps
module test_flash_security_lockout_recovery;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic por = 1'b0;
  logic debug_flash_req = 1'b0;
  logic tck, tms, tdi, tdo, tdo_oe_n, mass_erase_start, mass_erase_done;
  logic debug_flash_grant, emu_debug_enable, secured, erase_busy, erase_complete;
  logic [23:0] nv_addr;
  logic [15:0] nv_data, w;
  logic [6:0] erase_clk_div, div;
  logic [31:0] q;
  logic [31:0] seed = 32'hecdf;
  logic [15:0] words[$];
  int n_mismatch = 0;
  int total_checks = 0;
  int cyc;

  always #5 core_clk = ~core_clk;
  // Running count of cycles with the erase busy
  always @(negedge core_clk) cyc <= cyc + int'(erase_busy);

  // Block under test and its far side
  flash_security_lockout_recovery #(.TICKS(16)) i_dut (.core_clk, .rst, .por, .tck, .tms, .tdi,
    .tdo, .tdo_oe_n, .nv_addr, .nv_data, .debug_flash_req, .debug_flash_grant, .emu_debug_enable,
    .mass_erase_start, .mass_erase_done, .secured, .erase_busy, .erase_complete, .erase_clk_div);
  jtag_flash_partner i_part (.core_clk, .tck, .tms, .tdi, .tdo, .mass_erase_start,
    .mass_erase_done, .nv_data);

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", name, exp, got);
    end
  endtask : chk
  // Reset with a debug request standing across the exit
  task automatic do_reset(input logic p);
    @(negedge core_clk);
    rst <= !p;
    por <= p;
    debug_flash_req <= 1'b1;
    repeat (16) @(negedge core_clk);
    rst <= 1'b0;
    por <= 1'b0;
    repeat (12) @(negedge core_clk);
  endtask : do_reset
  // Status against the decoded word
  task automatic chk_state(input logic [15:0] wd);
    logic e;
    e = wd[1] && !wd[0];
    chk("secured", 32'(e), 32'(secured));
    chk("emu_debug_enable", 32'(!e), 32'(emu_debug_enable));
    chk("debug_flash_grant", 32'(!e), 32'(debug_flash_grant));
    chk("nv_addr", 32'h007ff7, 32'(nv_addr));
    debug_flash_req <= 1'b0;
  endtask : chk_state
  task automatic end_sim();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : end_sim

  // Hang guard
  initial
  begin
    #300000;
    n_mismatch++;
    end_sim();
  end

  // Main sequence
  initial
  begin
    for (int k = 0; k < 8; k++)
    begin
      seed = lfsr(seed);
      words.push_back({seed[15:2], k[1:0]});
    end
    foreach (words[k])
    begin
      i_part.load(words[k]);
      do_reset(k[2]);
      chk_state(words[k]);
    end
    seed = lfsr(seed);
    w = {seed[15:2], 2'b10};
    i_part.load(w);
    do_reset(1'b1);
    chk_state(w);
    i_part.tap_reset();
    i_part.scan(1'b0, 32, seed, q);
    chk("idcode", flash_security_pkg::ID_VALUE, q);
    chk("tdo_oe_n", 32'h1, 32'(tdo_oe_n));
    i_part.scan(1'b1, 4, 32'(flash_security_pkg::IR_UNLOCK), q);
    seed = lfsr(seed);
    div = seed[6:0];
    i_part.scan(1'b0, 7, 32'(div), q);
    for (int t = 0; t < 4000 && !erase_complete; t++)
      @(negedge core_clk);
    chk("erase_clk_div", 32'(div), 32'(erase_clk_div));
    chk("erase_long", 32'h1, 32'(cyc >= flash_security_pkg::ERASE_TICKS * (int'(div) + 1)));
    chk("erase_complete", 32'h1, 32'(erase_complete));
    debug_flash_req <= 1'b1;
    repeat (3) @(negedge core_clk);
    chk_state(w);
    do_reset(1'b1);
    chk_state(16'hffff);
    chk("erase_complete", 32'h0, 32'(erase_complete));
    end_sim();
  end
endmodule : test_flash_security_lockout_recovery
